// ### verilog/urc_pkg.sv
// constants and types for the receive command sender
// Function
// - send a status byte with line state, receive flags, vbus and id
// - status byte goes out only in synchronous mode with direction high
// - line state change with direction low sends a status byte at once
// - during receive, status bytes fill cycles with direction high, next low
// - during transmit, status bytes return only after stop is seen
// - any change of the condensed vbus code or of id sends a status byte
// - at start-up, after direction drops and stop is low, send one
// - leaving low-power, serial or carkit mode on stop sends one
// - line state sits in bits 1 to 0
// - vbus state sits in bits 3 to 2, 00 below session end
// - one idle turn-around cycle on each direction change
// - all link signals change on the device output clock
package urc_pkg;

  localparam int unsigned URC_SYNC_STAGES = 3;
  localparam logic [3:0]  URC_START_CYC   = 4'h8;
  localparam logic [3:0]  URC_CNT_ZERO    = 4'h0;
  localparam logic [7:0]  URC_BYTE_ZERO   = 8'h00;

  localparam logic [1:0] URC_VBUS_LOW   = 2'h0;
  localparam logic [1:0] URC_VBUS_SESS  = 2'h1;
  localparam logic [1:0] URC_VBUS_VALID = 2'h2;
  localparam logic [1:0] URC_VBUS_HIGH  = 2'h3;

  localparam logic [1:0] URC_EVT_NONE   = 2'h0;
  localparam logic [1:0] URC_EVT_ACTIVE = 2'h1;
  localparam logic [1:0] URC_EVT_ERROR  = 2'h3;

  // comparator and line levels as sampled from the analog front end
  typedef struct packed {
    logic [1:0] line_state;
    logic       session_end_flag;
    logic       session_valid;
    logic       vbus_valid;
    logic       id_level;
  } urc_pins_t;

  // condensed status carried across to the link clock
  typedef struct packed {
    logic [1:0] line_state;
    logic [1:0] vbus_code;
    logic       id_level;
  } urc_stat_t;

  typedef enum logic [2:0] {
    URC_ST_START   = 3'b000,
    URC_ST_IDLE    = 3'b001,
    URC_ST_TURN_UP = 3'b010,
    URC_ST_CMD     = 3'b011,
    URC_ST_RECV    = 3'b100,
    URC_ST_TURN_DN = 3'b101
  } urc_state_t;

endpackage

// ### verilog/urc_sync3.sv
// three stage synchroniser whose output moves only when the last two stages agree
`timescale 1ns/10ps
module urc_sync3
  import urc_pkg::*;
#(
  parameter int unsigned W = 1
)(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_nxt;

  always_comb
  begin
    q_nxt = q;
    if (s2_r == s3_r)
    begin
      q_nxt = s3_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q    <= '0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q    <= q_nxt;
    end
  end

endmodule

// ### verilog/urc_sender.sv
// receive command byte generator and bus scheduler for the transceiver side of the link
`timescale 1ns/10ps
module urc_sender
  import urc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire urc_pins_t  pins_async,
  input  wire logic       phy_clock_output,
  input  wire logic       ulpi_stp,
  input  wire logic       rx_active,
  input  wire logic       rx_valid,
  input  wire logic       rx_error,
  input  wire logic [7:0] rx_data,
  input  wire logic       tx_active,
  input  wire logic       mode_hold,
  output logic            ulpi_dir,
  output logic            ulpi_nxt,
  output logic [7:0]      ulpi_data_out,
  output logic            ulpi_data_oe_n,
  output logic            mode_exit
);

  // ---------------- system clock side: sample pins, detect changes ----------------
  urc_pins_t  pins_s;
  urc_stat_t  stat_now;
  urc_stat_t  stat_r;
  urc_stat_t  stat_nxt;
  urc_stat_t  snap_r;
  urc_stat_t  snap_nxt;
  logic       chg_pend_r;
  logic       chg_pend_nxt;
  logic       busy_r;
  logic       busy_nxt;
  logic       req_tgl_r;
  logic       req_tgl_nxt;
  logic       ack_s;
  logic       launch;

  urc_sync3 #(.W($bits(urc_pins_t))) u_pin_sync
  (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     (pins_async),
    .q     (pins_s)
  );

  always_comb
  begin
    stat_now.line_state = pins_s.line_state;
    stat_now.id_level   = pins_s.id_level;
    if (pins_s.session_end_flag || !pins_s.session_valid)
    begin
      stat_now.vbus_code = pins_s.session_end_flag ? URC_VBUS_LOW : URC_VBUS_SESS;
    end
    else
    begin
      stat_now.vbus_code = pins_s.vbus_valid ? URC_VBUS_HIGH : URC_VBUS_VALID;
    end
    stat_nxt = stat_now;
    // snapshot stays frozen while the other domain may be reading it
    launch       = chg_pend_r && !busy_r;
    snap_nxt     = launch ? stat_r : snap_r;
    req_tgl_nxt  = launch ? !req_tgl_r : req_tgl_r;
    busy_nxt     = launch || (busy_r && (ack_s != req_tgl_r));
    // a fresh change in the launch cycle keeps the flag set
    chg_pend_nxt = (stat_now != stat_r) || (chg_pend_r && !launch);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_r     <= '0;
      snap_r     <= '0;
      chg_pend_r <= 1'b0;
      busy_r     <= 1'b0;
      req_tgl_r  <= 1'b0;
    end
    else
    begin
      stat_r     <= stat_nxt;
      snap_r     <= snap_nxt;
      chg_pend_r <= chg_pend_nxt;
      busy_r     <= busy_nxt;
      req_tgl_r  <= req_tgl_nxt;
    end
  end

  // ---------------- link clock side ----------------
  logic       req_u;
  logic       ack_r;
  logic       ack_nxt;
  urc_stat_t  stat_u_r;
  urc_stat_t  stat_u_nxt;

  urc_sync3 #(.W(1)) u_req_sync
  (
    .clk   (phy_clock_output),
    .rst_n (rst_n),
    .d     (req_tgl_r),
    .q     (req_u)
  );

  urc_sync3 #(.W(1)) u_ack_sync
  (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     (ack_r),
    .q     (ack_s)
  );

  urc_state_t  st_r;
  urc_state_t  st_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic        cmd_pend_r;
  logic        cmd_pend_nxt;
  logic        start_pend_r;
  logic        start_pend_nxt;
  logic        tx_stp_r;
  logic        tx_stp_nxt;
  logic        dir_nxt;
  logic        nxt_nxt;
  logic [7:0]  data_nxt;
  logic        oe_n_nxt;
  logic        exit_nxt;
  logic        new_stat;
  logic        cmd_sent;
  logic        may_send;
  logic [7:0]  rxcmd;
  logic [1:0]  rx_evt;

  always_comb
  begin
    rx_evt = URC_EVT_NONE;
    if (rx_active)
    begin
      rx_evt = rx_error ? URC_EVT_ERROR : URC_EVT_ACTIVE;
    end
    rxcmd = {1'b0, stat_u_r.id_level, rx_evt, stat_u_r.vbus_code, stat_u_r.line_state};
  end

  always_comb
  begin
    new_stat   = (req_u != ack_r);
    ack_nxt    = req_u;
    stat_u_nxt = new_stat ? snap_r : stat_u_r;
    cmd_sent   = 1'b0;
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    dir_nxt    = 1'b1;
    nxt_nxt    = 1'b0;
    data_nxt   = URC_BYTE_ZERO;
    oe_n_nxt   = 1'b1;
    exit_nxt   = mode_hold && ulpi_stp;
    // a transmit in flight holds status bytes back until the link stops it
    tx_stp_nxt = tx_active && (tx_stp_r || ulpi_stp);
    may_send   = !mode_hold && (!tx_active || tx_stp_r) && !ulpi_stp;
    case (st_r)
      URC_ST_START:
      begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == URC_START_CYC)
        begin
          dir_nxt = 1'b0;
          st_nxt  = URC_ST_TURN_DN;
        end
      end
      URC_ST_IDLE:
      begin
        dir_nxt = 1'b0;
        if (!mode_hold && rx_active)
        begin
          dir_nxt = 1'b1;
          st_nxt  = URC_ST_TURN_UP;
        end
        else if (may_send && (cmd_pend_r || start_pend_r))
        begin
          dir_nxt = 1'b1;
          st_nxt  = URC_ST_TURN_UP;
        end
      end
      URC_ST_TURN_UP:
      begin
        st_nxt = rx_active ? URC_ST_RECV : URC_ST_CMD;
        if (rx_active)
        begin
          oe_n_nxt = 1'b0;
          nxt_nxt  = rx_valid;
          data_nxt = rx_valid ? rx_data : rxcmd;
          cmd_sent = !rx_valid;
        end
        else
        begin
          oe_n_nxt = 1'b0;
          data_nxt = rxcmd;
          cmd_sent = 1'b1;
        end
      end
      URC_ST_CMD:
      begin
        dir_nxt = 1'b0;
        st_nxt  = URC_ST_TURN_DN;
      end
      URC_ST_RECV:
      begin
        if (!rx_active)
        begin
          dir_nxt = 1'b0;
          st_nxt  = URC_ST_TURN_DN;
        end
        else
        begin
          oe_n_nxt = 1'b0;
          nxt_nxt  = rx_valid;
          data_nxt = rx_valid ? rx_data : rxcmd;
          cmd_sent = !rx_valid;
        end
      end
      URC_ST_TURN_DN:
      begin
        dir_nxt = 1'b0;
        st_nxt  = URC_ST_IDLE;
      end
      default:
      begin
        dir_nxt = 1'b0;
        st_nxt  = URC_ST_IDLE;
      end
    endcase
    // set wins over clear, so a change landing with a sent byte is not lost
    cmd_pend_nxt   = (cmd_pend_r && !cmd_sent) || new_stat || exit_nxt;
    start_pend_nxt = (start_pend_r && !cmd_sent) || ((st_r == URC_ST_START) && !dir_nxt);
  end

  // every link output is registered on the device clock
  always_ff @(posedge phy_clock_output or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r           <= URC_ST_START;
      cnt_r          <= URC_CNT_ZERO;
      ack_r          <= 1'b0;
      stat_u_r       <= '0;
      cmd_pend_r     <= 1'b0;
      start_pend_r   <= 1'b0;
      tx_stp_r       <= 1'b0;
      ulpi_dir       <= 1'b1;
      ulpi_nxt       <= 1'b0;
      ulpi_data_out  <= URC_BYTE_ZERO;
      ulpi_data_oe_n <= 1'b1;
      mode_exit      <= 1'b0;
    end
    else
    begin
      st_r           <= st_nxt;
      cnt_r          <= cnt_nxt;
      ack_r          <= ack_nxt;
      stat_u_r       <= stat_u_nxt;
      cmd_pend_r     <= cmd_pend_nxt;
      start_pend_r   <= start_pend_nxt;
      tx_stp_r       <= tx_stp_nxt;
      ulpi_dir       <= dir_nxt;
      ulpi_nxt       <= nxt_nxt;
      ulpi_data_out  <= data_nxt;
      ulpi_data_oe_n <= oe_n_nxt;
      mode_exit      <= exit_nxt;
    end
  end

endmodule

// ### tb/urc_link_model.sv
// link controller model: drives stop and collects status bytes
`timescale 1ns/10ps
module urc_link_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       stp_req,
  input  wire logic       dir,
  input  wire logic       nxt,
  input  wire logic [7:0] dout,
  input  wire logic       oe_n,
  output logic            stp,
  output logic [7:0]      rxcmd,
  output logic [7:0]      cnt
);
  logic dir_r;
  logic live_r;
  // a link only raises stop while it owns the bus
  assign stp = stp_req && !dir;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dir_r  <= 1'b0;
      live_r <= 1'b0;
      rxcmd  <= 8'h00;
      cnt    <= 8'h00;
    end
    else
    begin
      dir_r <= dir;
      // direction high straight out of reset is the start-up hold, not a status byte
      if (!dir)
      begin
        live_r <= 1'b1;
      end
      // skip turn-around; a released bus reads as the inverse of the last byte
      if (live_r && dir && dir_r && !nxt)
      begin
        rxcmd <= oe_n ? ~rxcmd : dout;
        cnt   <= cnt + 8'h01;
      end
    end
  end
endmodule

// ### tb/urc_sender_chk.sv
// bus timing assertions for the receive command sender
`timescale 1ns/10ps
module urc_sender_chk (
  input wire logic       phy_clock_output,
  input wire logic       rst_n,
  input wire logic       ulpi_stp,
  input wire logic       rx_active,
  input wire logic       tx_active,
  input wire logic       mode_hold,
  input wire logic       ulpi_dir,
  input wire logic       ulpi_nxt,
  input wire logic [7:0] ulpi_data_out,
  input wire logic       ulpi_data_oe_n,
  input wire logic       mode_exit
);
  logic stp_seen_r;
  logic stp_seen_nxt;
  default clocking @(posedge phy_clock_output); endclocking
  default disable iff (!rst_n);
  always_comb stp_seen_nxt = tx_active && (stp_seen_r || ulpi_stp);
  always_ff @(posedge phy_clock_output or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stp_seen_r <= 1'b0;
    end
    else
    begin
      stp_seen_r <= stp_seen_nxt;
    end
  end
  AST_OE_DIR: assert property (!ulpi_data_oe_n |-> ulpi_dir)
    else $error("bus driven without direction");
  AST_TURN: assert property ($changed(ulpi_dir) |-> ulpi_data_oe_n)
    else $error("bus driven in turn-around");
  AST_TURN_UP: assert property ($rose(ulpi_dir) |=> !ulpi_data_oe_n)
    else $error("no drive after turn-around");
  AST_NXT: assert property (ulpi_nxt |-> ulpi_dir && !ulpi_data_oe_n)
    else $error("next without driven bus");
  AST_BIT7: assert property (!ulpi_data_oe_n && !ulpi_nxt |-> !ulpi_data_out[7])
    else $error("status bit 7 set");
  AST_DROP: assert property (ulpi_dir && !ulpi_data_oe_n && !rx_active |=> !ulpi_dir)
    else $error("direction kept after receive");
  AST_TX: assert property ($rose(ulpi_dir) |-> !$past(tx_active) || $past(stp_seen_r)
    || $past(ulpi_stp) || $past(rx_active))
    else $error("status sent in transmit before stop");
  AST_MODE: assert property (mode_hold && ulpi_stp |=> mode_exit)
    else $error("no mode exit pulse");
endmodule
bind urc_sender urc_sender_chk i_urc_sender_chk (.phy_clock_output(phy_clock_output), .rst_n(rst_n),
  .ulpi_stp(ulpi_stp), .rx_active(rx_active), .tx_active(tx_active), .mode_hold(mode_hold),
  .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_data_out(ulpi_data_out),
  .ulpi_data_oe_n(ulpi_data_oe_n), .mode_exit(mode_exit));

// ### tb/test_urc_sender.sv
// self-checking bench for the receive command sender
`timescale 1ns/10ps
module test_urc_sender
  import urc_pkg::*;
;
  typedef struct packed {urc_pins_t pins; logic [7:0] stat;} urc_row_t;
  logic       sys_clk, rst_n, phy_clock_output, ulpi_stp, stp_req, rx_active, rx_valid, rx_error;
  logic       tx_active, mode_hold, ulpi_dir, ulpi_nxt, ulpi_data_oe_n, mode_exit;
  logic [7:0] rx_data, ulpi_data_out, rxcmd, cnt, n0;
  urc_pins_t  pins;
  int         fails, cmp_count;
  urc_row_t   rows [5] = '{'{6'h18, 8'h01}, '{6'h21, 8'h46}, '{6'h05, 8'h48}, '{6'h36, 8'h0F}, '{6'h37, 8'h4F}};
  urc_sender i_urc_sender (.sys_clk(sys_clk), .rst_n(rst_n), .pins_async(pins),
    .phy_clock_output(phy_clock_output), .ulpi_stp(ulpi_stp), .rx_active(rx_active), .rx_valid(rx_valid),
    .rx_error(rx_error), .rx_data(rx_data), .tx_active(tx_active), .mode_hold(mode_hold), .ulpi_dir(ulpi_dir),
    .ulpi_nxt(ulpi_nxt), .ulpi_data_out(ulpi_data_out), .ulpi_data_oe_n(ulpi_data_oe_n), .mode_exit(mode_exit));
  urc_link_model i_urc_link_model (.clk(phy_clock_output), .rst_n(rst_n), .stp_req(stp_req), .dir(ulpi_dir),
    .nxt(ulpi_nxt), .dout(ulpi_data_out), .oe_n(ulpi_data_oe_n), .stp(ulpi_stp), .rxcmd(rxcmd), .cnt(cnt));
  initial
  begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial
  begin
    phy_clock_output = 0;
    #3;
    forever #6 phy_clock_output = ~phy_clock_output;
  end
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  // a byte that never comes shows up as a wrong count, not as a silent pass
  task automatic wait_byte;
    int k;
    logic [7:0] c0;
    c0 = cnt;
    k = 0;
    while (cnt === c0 && k < 80)
    begin
      @(posedge phy_clock_output);
      k++;
    end
    check("arrival", c0 + 8'h01, cnt);
  endtask
  task automatic wait_cmd(input logic [7:0] e);
    wait_byte;
    check("status", e, rxcmd);
  endtask
  task automatic start_up(input logic [7:0] e);
    check("dir_rst", 8'h01, {7'h00, ulpi_dir});
    check("oe_rst", 8'h01, {7'h00, ulpi_data_oe_n});
    check("nxt_rst", 8'h00, {7'h00, ulpi_nxt});
    check("data_rst", 8'h00, ulpi_data_out);
    check("exit_rst", 8'h00, {7'h00, mode_exit});
    rst_n = 1;
    // the first byte may still carry the reset status; the settled one follows
    wait_byte;
    repeat (40) @(posedge phy_clock_output);
    check("start_stat", e, rxcmd);
  endtask
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    fails++;
    end_of_test;
  end
  initial
  begin
    {rst_n, stp_req, rx_active, rx_valid, rx_error, tx_active, mode_hold} = '0;
    {fails, cmp_count} = '0;
    pins = 6'h37;
    rx_data = 8'hA5;
    repeat (8) @(negedge sys_clk);
    start_up(8'h4F);
    for (int i = 0; i < 5; i++)
    begin
      @(negedge sys_clk);
      pins = rows[i].pins;
      wait_cmd(rows[i].stat);
    end
    @(negedge phy_clock_output);
    {rx_active, rx_error} = 2'h3;
    wait_cmd(8'h7F);
    @(negedge phy_clock_output);
    rx_error = 0;
    wait_byte;
    wait_cmd(8'h5F);
    @(negedge phy_clock_output);
    rx_valid = 1;
    @(negedge phy_clock_output);
    {rx_valid, rx_active, rx_error} = 3'h0;
    check("nxt", 8'h01, {7'h00, ulpi_nxt});
    check("rx_data", 8'hA5, ulpi_data_out);
    repeat (20) @(negedge phy_clock_output);
    tx_active = 1;
    @(negedge sys_clk);
    pins = 6'h18;
    n0 = cnt;
    repeat (60) @(negedge phy_clock_output);
    check("tx_hold", n0, cnt);
    stp_req = 1;
    @(negedge phy_clock_output);
    stp_req = 0;
    wait_cmd(8'h01);
    @(negedge phy_clock_output);
    tx_active = 0;
    {mode_hold, stp_req} = 2'h3;
    @(negedge phy_clock_output);
    stp_req = 0;
    check("mode_exit", 8'h01, {7'h00, mode_exit});
    mode_hold = 0;
    wait_cmd(8'h01);
    @(negedge sys_clk);
    rst_n = 0;
    repeat (8) @(negedge sys_clk);
    start_up(8'h01);
    end_of_test;
  end
endmodule
